// ---- src/wfd_pkg.sv ----
// Shared constants, register map and helper functions for the wake detect block.
// Assumes one clock domain and an AXI4-Lite master with 32-bit data.
package wfd_pkg;

    // Register map: byte addresses on the AXI4-Lite bus.
    localparam logic [7:0] STORE_BASE = 8'h00;
    localparam int STORE_WORDS = 8;
    localparam logic [7:0] CSR_ADDR = 8'h20;

    // Filter storage word layout.
    localparam int CMD_WORD = 4;
    localparam int OFFSET_WORD = 5;
    localparam int CRC_WORD = 6;
    localparam int CMD_EN_BIT = 0;
    localparam int CMD_MCAST_BIT = 3;
    localparam int NUM_FILTERS = 4;
    localparam int MASK_BITS = 31;

    // Wake control and status bits.
    localparam int CSR_SYNC_EN = 0;
    localparam int CSR_FRAME_EN = 1;
    localparam int CSR_PME_SEL = 2;
    localparam int CSR_SYNC_FLAG = 4;
    localparam int CSR_FRAME_FLAG = 5;

    // Frame layout and sync pattern.
    localparam int ADDR_BYTES = 6;
    localparam int DA_SA_LEN = 12;
    localparam int SYNC_LEN = 6;
    localparam int ADDR_COPIES = 16;
    localparam logic [7:0] SYNC_BYTE = 8'hff;

    // CRC-16 engine.
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hffff;

    // AXI responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Byte k of the station address, k = 0 is the first byte on the wire.
    function automatic logic [7:0] addr_byte(input logic [47:0] addr, input logic [2:0] k);
        return addr[{k, 3'h0} +: 8];
    endfunction

    // One byte through the CRC-16 engine, least significant bit first.
    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
        logic [15:0] c;
        c = crc;
        for (int b = 0; b < 8; b++)
        begin
            if (c[15] ^ d[b])
                c = {c[14:0], 1'b0} ^ CRC_POLY;
            else
                c = {c[14:0], 1'b0};
        end
        return c;
    endfunction

endpackage

// ---- src/wfd_filter_lane.sv ----
// One wake-up frame filter lane: selects masked bytes and advances its CRC-16.
// Assumes the byte index counts from the first destination address byte.
`timescale 1ns/10ps
module wfd_filter_lane #(
    parameter int IDX_W = 9
) (
    // Received byte and its position in the frame.
    input wire logic [7:0] rx_data,
    input wire logic [IDX_W-1:0] byte_idx,
    input wire logic sof,
    // Filter programming.
    input wire logic [31:0] byte_mask,
    input wire logic [7:0] pattern_offset,
    // Running CRC of this lane.
    input wire logic [15:0] crc_q,
    output logic [15:0] crc_next
);

    logic [IDX_W-1:0] rel;
    logic [15:0] base;
    logic take;

    // A byte counts when it lies in the 31-byte window after the offset and its
    // mask bit is set; bit 31 never takes part even if software sets it.
    always_comb
    begin
        rel = byte_idx - IDX_W'(pattern_offset);
        take = (byte_idx >= IDX_W'(pattern_offset)) && (rel < IDX_W'(wfd_pkg::MASK_BITS))
            && byte_mask[rel[4:0]];
        base = sof ? wfd_pkg::CRC_INIT : crc_q;
        crc_next = take ? wfd_pkg::crc16_byte(base, rx_data) : base;
    end

endmodule

// ---- src/wfd_sync_detect.sv ----
// Sync-pattern packet detector: six 0xff bytes then sixteen station address copies.
// Assumes bytes arrive on the same clock with a start flag on the first byte.
`timescale 1ns/10ps
module wfd_sync_detect (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Byte stream.
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    // Qualification.
    input wire logic enable,
    input wire logic [47:0] station_addr,
    // Result.
    output logic hit
);

    typedef enum logic [1:0] {
        WFD_SEARCH = 2'b00,
        WFD_ADDR = 2'b01,
        WFD_DONE = 2'b11
    } wfd_sync_e;

    typedef struct packed {
        wfd_sync_e st;
        logic [3:0] idx;
        logic [2:0] run;
        logic [2:0] k;
        logic [3:0] copies;
        logic hit;
    } wfd_sync_s;

    wfd_sync_s q;
    wfd_sync_s next_q;
    wfd_sync_s b;

    // Each frame starts from a clean search; the header bytes are skipped.
    always_comb
    begin
        next_q = q;
        next_q.hit = 1'b0;
        b = q;
        if (rx_sof)
        begin
            b = '0;
        end
        if (rx_valid)
        begin
            next_q = b;
            next_q.hit = 1'b0;
            if (b.idx < 4'(wfd_pkg::DA_SA_LEN))
                next_q.idx = b.idx + 4'h1;
            if (!enable)
                next_q.st = WFD_SEARCH;
            else if (b.idx >= 4'(wfd_pkg::DA_SA_LEN))
            begin
                unique case (b.st)
                    WFD_SEARCH:
                    begin
                        if (rx_data == wfd_pkg::SYNC_BYTE)
                            next_q.run = (b.run == 3'(wfd_pkg::SYNC_LEN)) ? b.run : b.run + 3'h1;
                        else if (b.run == 3'(wfd_pkg::SYNC_LEN)
                            && rx_data == wfd_pkg::addr_byte(station_addr, 3'h0))
                        begin
                            next_q.st = WFD_ADDR;
                            next_q.k = 3'h1;
                            next_q.copies = 4'h0;
                        end
                        else
                            next_q.run = 3'h0;
                    end
                    WFD_ADDR:
                    begin
                        if (rx_data == wfd_pkg::addr_byte(station_addr, b.k))
                        begin
                            if (b.k == 3'(wfd_pkg::ADDR_BYTES - 1))
                            begin
                                next_q.k = 3'h0;
                                next_q.copies = b.copies + 4'h1;
                                if (b.copies == 4'(wfd_pkg::ADDR_COPIES - 1))
                                begin
                                    next_q.st = WFD_DONE;
                                    next_q.hit = 1'b1;
                                end
                            end
                            else
                                next_q.k = b.k + 3'h1;
                        end
                        else
                        begin
                            // A broken copy sends us back to look for a fresh sync run.
                            next_q.st = WFD_SEARCH;
                            next_q.run = (rx_data == wfd_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
                        end
                    end
                    WFD_DONE:
                    begin
                        next_q.st = WFD_DONE;
                    end
                    default:
                    begin
                        next_q.st = WFD_SEARCH;
                    end
                endcase
            end
        end
    end

    // State register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else
            q <= next_q;
    end

    assign hit = q.hit;

endmodule

// ---- src/wfd_wake_detect.sv ----
// Wake-up frame filters and sync-packet detection with an AXI4-Lite register slave.
// Assumes the receive path delivers destination-address-first bytes on aclk.
//
// Function
// - Byte mask bits 30:0 select frame byte offset+j for the CRC; bit 31 unused.
// - Command bit 3 set means multicast frames only, clear means unicast only.
// - Command bit 0 enables the filter; a disabled filter never matches.
// - Offsets count from the first destination address byte of the frame.
// - Masked-byte CRC-16 equal to the stored value declares a wake-up frame.
// - Storage is four masks, commands word, offsets word, then two CRC words.
// - Sync wake enable suppresses normal reception and starts sync detection.
// - Software chooses host interrupt or power event output for notification.
// - A detected sync packet sets the sync received status flag.
// - Clearing sync wake enable returns to normal reception if frame wake enable is also clear and D1 is not active.
// - Sync detection applies to own-address and broadcast frames.
// - The sync run of six 0xff bytes is sought after both address fields.
// - Sixteen back-to-back station address copies must follow the sync run.
// - A broken copy sequence restarts the search for a sync run.
// - The pattern may start anywhere but copies need the sync run first.
// - Multicast frames holding the pattern are accepted too.
// - In D1 both detectors run regardless of their enable bits.
// - Frame wake enable suppresses reception; a match sets the frame flag.
// - Broadcast wake frames wake the device even with broadcasts disabled.
`timescale 1ns/10ps
module wfd_wake_detect #(
    parameter int ADDR_W = 8,
    parameter int IDX_W = 9
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive byte stream from the MAC.
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_sof,
    input wire logic rx_eof,
    // Station context.
    input wire logic [47:0] station_addr,
    input wire logic power_state_d1,
    // Results.
    output logic normal_rx_enable,
    output logic host_irq,
    output logic power_event_output
);

    localparam int NF = wfd_pkg::NUM_FILTERS;

    typedef struct packed {
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [wfd_pkg::STORE_WORDS-1:0][31:0] store;
        logic sync_en;
        logic frame_en;
        logic pme_sel;
        logic sync_flag;
        logic frame_flag;
        logic [IDX_W-1:0] byte_idx;
        logic mcast;
        logic da_own;
        logic [NF-1:0][15:0] crc;
    } wfd_state_s;

    wfd_state_s q;
    wfd_state_s next_q;
    logic [NF-1:0][15:0] lane_crc;
    logic [NF-1:0] frame_hits;
    logic [IDX_W-1:0] cur_idx;
    logic sync_run;
    logic frame_run;
    logic sync_raw;
    logic sync_hit;
    logic frame_any;
    logic [31:0] wmerged;

    // Byte-lane merge of a write into an existing word.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction

    // Field pickers over the filter storage.
    function automatic logic cmd_of(input logic [wfd_pkg::STORE_WORDS-1:0][31:0] s,
        input int i, input int b);
        return s[wfd_pkg::CMD_WORD][i*8 + b];
    endfunction

    function automatic logic [15:0] crc_of(input logic [wfd_pkg::STORE_WORDS-1:0][31:0] s,
        input int i);
        return s[wfd_pkg::CRC_WORD + i/2][(i%2)*16 +: 16];
    endfunction

    // Current byte position; the start flag forces zero at the destination address.
    assign cur_idx = rx_sof ? '0 : q.byte_idx;

    // D1 turns both detectors on without software help.
    assign sync_run = q.sync_en || power_state_d1;
    assign frame_run = q.frame_en || power_state_d1;

    // Normal reception stops while either detector owns the receive path.
    assign normal_rx_enable = !(sync_run || frame_run);

    // Notification goes to exactly one output, picked by software.
    assign host_irq = !q.pme_sel && (q.sync_flag || q.frame_flag);
    assign power_event_output = q.pme_sel && (q.sync_flag || q.frame_flag);

    // One CRC lane per filter; each keeps its own running value.
    for (genvar g = 0; g < NF; g++)
    begin : g_lane
        wfd_filter_lane #(
            .IDX_W(IDX_W)
        ) u_lane (
            .rx_data(rx_data),
            .byte_idx(cur_idx),
            .sof(rx_sof),
            .byte_mask(q.store[g]),
            .pattern_offset(q.store[wfd_pkg::OFFSET_WORD][g*8 +: 8]),
            .crc_q(q.crc[g]),
            .crc_next(lane_crc[g])
        );
    end

    // Sync pattern search runs on every byte while sync_run is set.
    wfd_sync_detect u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx_valid(rx_valid),
        .rx_data(rx_data),
        .rx_sof(rx_sof),
        .enable(sync_run),
        .station_addr(station_addr),
        .hit(sync_raw)
    );

    // Own address, broadcast or any multicast frame may carry the sync pattern.
    assign sync_hit = sync_raw && (q.da_own || q.mcast);

    // Per-filter match on the last byte of the frame. Broadcast frames have the
    // group bit set, so they pass a multicast filter whatever the broadcast
    // disable setting of the receive filter is.
    always_comb
    begin
        frame_hits = '0;
        for (int i = 0; i < NF; i++)
        begin
            frame_hits[i] = rx_valid && rx_eof && frame_run
                && cmd_of(q.store, i, wfd_pkg::CMD_EN_BIT)
                && (cmd_of(q.store, i, wfd_pkg::CMD_MCAST_BIT) ? q.mcast
                    : (q.da_own && !q.mcast))
                && (lane_crc[i] == crc_of(q.store, i));
        end
    end

    assign frame_any = |frame_hits;
    assign wmerged = merge(q.store[q.aw_addr[4:2]], q.w_data, q.w_strb);

    // All next-state logic: bus slave, frame tracking and status flags.
    always_comb
    begin
        next_q = q;
        // Address and data are taken independently and in either order.
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_q.aw_got = 1'b1;
            next_q.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_q.w_got = 1'b1;
            next_q.w_data = s_axi_wdata;
            next_q.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready)
            next_q.bvalid = 1'b0;
        if (q.aw_got && q.w_got && !q.bvalid)
        begin
            next_q.aw_got = 1'b0;
            next_q.w_got = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = wfd_pkg::RESP_OKAY;
            if (q.aw_addr < ADDR_W'(wfd_pkg::CSR_ADDR))
                next_q.store[q.aw_addr[4:2]] = wmerged;
            else if (q.aw_addr[ADDR_W-1:2] == wfd_pkg::CSR_ADDR[ADDR_W-1:2])
            begin
                if (q.w_strb[0])
                begin
                    next_q.sync_en = q.w_data[wfd_pkg::CSR_SYNC_EN];
                    next_q.frame_en = q.w_data[wfd_pkg::CSR_FRAME_EN];
                    next_q.pme_sel = q.w_data[wfd_pkg::CSR_PME_SEL];
                    // Writing one clears a flag.
                    if (q.w_data[wfd_pkg::CSR_SYNC_FLAG])
                        next_q.sync_flag = 1'b0;
                    if (q.w_data[wfd_pkg::CSR_FRAME_FLAG])
                        next_q.frame_flag = 1'b0;
                end
            end
            else
                next_q.bresp = wfd_pkg::RESP_SLVERR;
        end
        // Reads answer one cycle after the address is taken.
        if (q.rvalid && s_axi_rready)
            next_q.rvalid = 1'b0;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_q.rvalid = 1'b1;
            next_q.rresp = wfd_pkg::RESP_OKAY;
            next_q.rdata = '0;
            if (s_axi_araddr < ADDR_W'(wfd_pkg::CSR_ADDR))
                next_q.rdata = q.store[s_axi_araddr[4:2]];
            else if (s_axi_araddr[ADDR_W-1:2] == wfd_pkg::CSR_ADDR[ADDR_W-1:2])
            begin
                next_q.rdata[wfd_pkg::CSR_SYNC_EN] = q.sync_en;
                next_q.rdata[wfd_pkg::CSR_FRAME_EN] = q.frame_en;
                next_q.rdata[wfd_pkg::CSR_PME_SEL] = q.pme_sel;
                next_q.rdata[wfd_pkg::CSR_SYNC_FLAG] = q.sync_flag;
                next_q.rdata[wfd_pkg::CSR_FRAME_FLAG] = q.frame_flag;
            end
            else
                next_q.rresp = wfd_pkg::RESP_SLVERR;
        end
        // Frame tracking: position, group bit and own-address compare.
        if (rx_valid)
        begin
            next_q.crc = lane_crc;
            if (cur_idx != '1)
                next_q.byte_idx = cur_idx + IDX_W'(1);
            if (cur_idx == '0)
            begin
                next_q.mcast = rx_data[0];
                next_q.da_own = (rx_data == wfd_pkg::addr_byte(station_addr, 3'h0));
            end
            else if (cur_idx < IDX_W'(wfd_pkg::ADDR_BYTES))
                next_q.da_own = q.da_own
                    && (rx_data == wfd_pkg::addr_byte(station_addr, cur_idx[2:0]));
        end
        // Hardware set wins over a software clear in the same cycle.
        if (sync_hit)
            next_q.sync_flag = 1'b1;
        if (frame_any)
            next_q.frame_flag = 1'b1;
    end

    // State register.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            q <= '0;
        else
            q <= next_q;
    end

    // Bus handshakes: one write and one read in flight.
    assign s_axi_awready = !q.aw_got && !q.bvalid;
    assign s_axi_wready = !q.w_got && !q.bvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    // Checks.
    chk_filter_off_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(q.frame_flag) |-> $past(cmd_of(q.store, 3, 0) || cmd_of(q.store, 2, 0)
        || cmd_of(q.store, 1, 0) || cmd_of(q.store, 0, 0)))
        else $error("Disabled filter reported a match.");
    chk_sync_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        sync_hit |=> q.sync_flag)
        else $error("Sync flag not set after detection.");
    chk_frame_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
        frame_any |=> q.frame_flag)
        else $error("Frame flag not set after match.");
    chk_rx_suppress_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.sync_en || q.frame_en) |-> !normal_rx_enable)
        else $error("Normal reception active in wake mode.");
    chk_d1_auto_enable: assert property (@(posedge aclk) disable iff (!aresetn)
        power_state_d1 |-> !normal_rx_enable)
        else $error("Detectors not running in D1.");
    chk_notify_route_sel: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.sync_flag && q.pme_sel) |-> (power_event_output && !host_irq))
        else $error("Notification on wrong output.");
    chk_sync_dest_ok: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(q.sync_flag) |-> $past(q.da_own || q.mcast))
        else $error("Sync detection on foreign unicast frame.");
    chk_crc_hold_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !rx_valid |=> $stable(q.crc))
        else $error("CRC moved without a byte.");
    chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
        (q.aw_got && q.w_got && !q.bvalid) |=> q.bvalid)
        else $error("Write response missing.");

endmodule

// ---- sim/wfd_rx_model.sv ----
// Receive byte source standing in for the MAC receive path of the block.
// Assumes the caller enters send just after a rising edge of aclk.
`timescale 1ns/10ps
module wfd_rx_model (
    // Clock.
    input wire logic aclk,
    // Byte stream towards the block.
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_sof,
    output logic rx_eof
);
    // Idle stream at time zero.
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h5a;
        rx_sof = 1'b0;
        rx_eof = 1'b0;
    end

    // Sends one frame; slow mode leaves a gap after every byte. Idle data shows
    // the inverse of the last byte, so stale data can never pass for a match.
    task automatic send(input logic [7:0] q[$], input bit slow);
        for (int i = 0; i < q.size(); i++)
        begin
            rx_valid <= 1'b1;
            rx_data <= q[i];
            rx_sof <= (i == 0);
            rx_eof <= (i == q.size() - 1);
            @(posedge aclk);
            if (slow || i == q.size() - 1)
            begin
                rx_valid <= 1'b0;
                rx_data <= ~q[i];
                rx_sof <= 1'b0;
                rx_eof <= 1'b0;
                @(posedge aclk);
            end
        end
    endtask
endmodule

// ---- sim/wfd_testbench.sv ----
// Self-checking bench for the wake detect block: registers, filters, sync packets.
// Assumes the receive model drives frames and this bench is the AXI4-Lite master.
`timescale 1ns/10ps
module testbench;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic rx_valid, rx_sof, rx_eof, power_state_d1, normal_rx_enable, host_irq;
    logic power_event_output;
    logic [7:0] s_axi_awaddr, s_axi_araddr, rx_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [47:0] station_addr;
    logic [7:0] fq[$];
    logic [7:0] pat[4] = '{8'h08, 8'h06, 8'h5a, 8'ha5};
    int fail_count, comparisons;

    wfd_wake_detect u_wfd_wake_detect (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rx_valid, .rx_data, .rx_sof, .rx_eof, .station_addr, .power_state_d1,
        .normal_rx_enable, .host_irq, .power_event_output);
    wfd_rx_model u_wfd_rx_model (.aclk, .rx_valid, .rx_data, .rx_sof, .rx_eof);

    // Free-running 250 MHz clock.
    initial
    begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // Expected CRC-16 worked out here, poly 0x8005, init 0xffff, LSB first.
    function automatic logic [15:0] crc_of(input logic [7:0] d[4]);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < 4; i++)
            for (int b = 0; b < 8; b++)
                c = (c[15] ^ d[i][b]) ? ({c[14:0], 1'b0} ^ 16'h8005) : {c[14:0], 1'b0};
        return c;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Write cycle: both channels offered together, each released when taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Reads the status word and compares its two received flags only.
    task automatic csr_flags(input logic [31:0] exp);
        axi_rd(wfd_pkg::CSR_ADDR, rd, rs);
        check(rd & 32'h30, exp);
    endtask

    // Header kinds: 0 own, 1 broadcast, 2 multicast, 3 foreign unicast.
    task automatic add_hdr(input int kind);
        fq.delete();
        for (int k = 0; k < 6; k++)
            fq.push_back(kind == 1 ? 8'hff : kind == 2 ? 8'h01 :
                station_addr[8*k+:8] ^ (kind == 3 ? 8'h40 : 8'h00));
        for (int k = 0; k < 6; k++)
            fq.push_back(8'(8'h0a + k));
    endtask

    task automatic add_sync(input int n);
        repeat (6) fq.push_back(8'hff);
        for (int c = 0; c < n * 6; c++)
            fq.push_back(station_addr[8*(c%6)+:8]);
    endtask

    // Sends the queued frame and lets the flag latency pass.
    task automatic send_wait(input bit slow);
        u_wfd_rx_model.send(fq, slow);
        repeat (3) @(posedge aclk);
    endtask

    // Reset state, full filter store load, readback and an unmapped place.
    task automatic t_regs;
        logic [31:0] w[8] = '{32'hf, 0, 0, 0, 32'h1, 32'hc, {16'h0, crc_of(pat)}, 0};
        check(normal_rx_enable, 1'b1);
        csr_flags(32'h0);
        for (int i = 0; i < 8; i++)
            axi_wr(8'(4 * i), w[i], rs);
        axi_rd(8'h18, rd, rs);
        check(rd, w[6]);
        axi_rd(8'h14, rd, rs);
        check(rd, 32'hc);
        axi_wr(8'h24, 32'hffffffff, rs);
        check(rs, wfd_pkg::RESP_SLVERR);
        axi_rd(8'h24, rd, rs);
        check(rs, wfd_pkg::RESP_SLVERR);
        check(rd, 32'h0);
    endtask

    // Filter 0 matches on its masked bytes; disabled or multicast-only refuses.
    task automatic t_frame;
        logic [31:0] cmd[2] = '{32'h0, 32'h9};
        axi_wr(wfd_pkg::CSR_ADDR, 32'h2, rs);
        check(normal_rx_enable, 1'b0);
        add_hdr(0);
        foreach (pat[i]) fq.push_back(pat[i]);
        fq.push_back(8'h01);
        send_wait(1);
        csr_flags(32'h20);
        check(host_irq, 1'b1);
        axi_wr(wfd_pkg::CSR_ADDR, 32'h22, rs);
        foreach (cmd[i])
        begin
            axi_wr(8'h10, cmd[i], rs);
            send_wait(0);
            csr_flags(32'h0);
        end
        axi_wr(wfd_pkg::CSR_ADDR, 32'h0, rs);
        check(normal_rx_enable, 1'b1);
    endtask

    // Broken copy run, then a full pattern later in the frame, on the event pin.
    task automatic t_sync;
        axi_wr(wfd_pkg::CSR_ADDR, 32'h5, rs);
        check(normal_rx_enable, 1'b0);
        add_hdr(1);
        add_sync(15);
        fq.push_back(8'h00);
        send_wait(0);
        csr_flags(32'h0);
        fq.pop_back();
        add_sync(16);
        send_wait(1);
        csr_flags(32'h10);
        check({power_event_output, host_irq}, 2'b10);
        axi_wr(wfd_pkg::CSR_ADDR, 32'h10, rs);
        check(normal_rx_enable, 1'b1);
    endtask

    // D1 runs detection with enables clear; foreign unicast is ignored.
    task automatic t_d1;
        power_state_d1 <= 1'b1;
        @(posedge aclk);
        check(normal_rx_enable, 1'b0);
        add_hdr(3);
        add_sync(16);
        send_wait(0);
        csr_flags(32'h0);
        add_hdr(2);
        add_sync(16);
        send_wait(0);
        csr_flags(32'h10);
        power_state_d1 <= 1'b0;
    endtask

    // Main sequence: inputs at time zero, six reset cycles, then scenarios.
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, power_state_d1, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        station_addr = 48'h665544332210;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_frame();
        t_sync();
        t_d1();
        summarize();
    end

    // Watchdog: the scenarios need a few thousand cycles at most.
    initial
    begin
        #100000;
        fail_count++;
        summarize();
    end
endmodule
